/* File: shared/dhc_map.svh */
// register map, field positions, reset values and timing of the line-access control bank
// How it works
// RL1: software never writes unmapped, reserved addresses
// RL2: soft reset bit restores every register
// RL3: reserved bits and registers read zero
// RL4: main control bit 1 enables barrier loopback
// RL5: format clear: 15-bit, data LSB requests secondary
// RL6: format set: 16-bit, secondary sync pin starts
// RL7: path control bit 3 enables analog loopback
// RL8: hybrid connect bit, resets to one
// RL9: receive path enable bit 0, resets one
// RL10: polarity bit 4 sets hook pin level
// RL11: on-hook monitor bit 3 enables low-power monitoring
// RL12: ring flag holds, clears after timeout or off-hook
// RL13: hook pin ignored unless its enable set
// RL14: off-hook equals command OR enabled active pin
// RL15: line powerdown bit holds line side down
// RL16: software ignores line status without frame detect
// RL17: read returns contents plus status next frame
// RL18: software enables at most one test mode
`ifndef DHC_MAP_SVH
`define DHC_MAP_SVH
`define DHC_REG_MAIN       5'h01
`define DHC_REG_PATH       5'h02
`define DHC_REG_LINE       5'h05
`define DHC_REG_LINE_TWO   5'h06
`define DHC_REG_PLL1_DIV   5'h07
`define DHC_REG_PLL1_MUL   5'h08
`define DHC_REG_PLL2       5'h09
`define DHC_REG_PLL_MODE   5'h0A
`define DHC_REG_VERSION    5'h0B
`define DHC_REG_STATE      5'h0C
`define DHC_REG_GAIN_VER   5'h0D
`define DHC_REG_CHAIN      5'h0E
`define DHC_REG_GAIN       5'h0F
`define DHC_REG_FILTER     5'h10
`define DHC_REG_CAL        5'h11
`define DHC_REG_FIRST      5'h01
`define DHC_REG_LAST       5'h11
// writable bits of each register
`define DHC_WM_MAIN        8'h03
`define DHC_WM_PATH        8'h0B
`define DHC_WM_LINE        8'h1B
`define DHC_WM_LINE_TWO    8'hFB
`define DHC_WM_FULL        8'hFF
`define DHC_WM_PLL_MODE    8'h01
`define DHC_WM_GAIN_VER    8'h03
`define DHC_WM_FILTER      8'h10
`define DHC_WM_CAL         8'h60
`define DHC_WM_NONE        8'h00
`define DHC_RST_PATH       8'h03
`define DHC_RST_LINE_TWO   8'h70
`define DHC_RST_ZERO       8'h00
`define DHC_FILTER_FIXED   8'h08
// field positions
`define DHC_B_SOFT_RESET   7
`define DHC_B_BARRIER_LOOP 1
`define DHC_B_FORMAT       0
`define DHC_B_ANALOG_LOOP  3
`define DHC_B_HYBRID       1
`define DHC_B_RX_EN        0
`define DHC_B_HOOK_POL     4
`define DHC_B_MONITOR      3
`define DHC_B_RING         2
`define DHC_B_HOOK_PIN_EN  1
`define DHC_B_GO_OFFHOOK   0
`define DHC_B_PUMP_EN      7
`define DHC_B_LINE_PD      4
`define DHC_B_HOST_PD      3
`define DHC_B_LINK_ERR     7
`define DHC_B_FRAME_DET    6
`define DHC_B_LINE_ID      6
`define DHC_B_FILTER_EN    4
`define DHC_B_CAL_MANUAL   6
`define DHC_B_CAL_AUTO_OFF 5
// timing
`define DHC_CLK_HZ         40000000
`define DHC_RING_HOLD_MS   4500
// host revision code: the value is arbitrary
`define DHC_HOST_VERSION   4'h3
`endif

/* File: shared/dhc_pkg.sv */
// types shared by the line-access control bank
package dhc_pkg;
  typedef struct packed {
    logic       rd;
    logic [4:0] addr;
    logic [7:0] data;
  } dhc_cmd_t;
  typedef struct packed {
    logic       link_frame_detect;
    logic       link_error_evt;
    logic [3:0] loop_current;
    logic       line_id_bit;
    logic [3:0] line_version;
    logic       ring_pulse;
  } dhc_line_t;
  typedef struct packed {
    logic       barrier_loopback_en;
    logic       frame_format_sel;
    logic       analog_loop_en;
    logic       hybrid_connect;
    logic       receive_path_en;
    logic       hook_pin_polarity;
    logic       onhook_monitor_en;
    logic       hook_pin_en;
    logic       go_offhook;
    logic       charge_pump_en;
    logic       line_side_powerdown;
    logic       host_powerdown;
    logic [1:0] aout_tx_lvl;
    logic [1:0] aout_rx_lvl;
    logic [7:0] pll1_div;
    logic [7:0] pll1_mul;
    logic [7:0] pll2_ratio;
    logic       pll_mode;
    logic [7:0] chain_cfg;
    logic [7:0] gain_cfg;
    logic       filter_en;
    logic       cal_manual;
    logic       cal_auto_off;
    logic [1:0] gain_trim;
  } dhc_ctrl_t;
  typedef enum logic [1:0] {
    DHC_SEC_IDLE   = 2'b00,
    DHC_SEC_WAIT   = 2'b01,
    DHC_SEC_ANSWER = 2'b10
  } dhc_sec_state_t;
endpackage

/* File: hdl/dhc_regs.sv */
// control register bank reached over the secondary frames of the serial port
`timescale 1ns/10ps
`include "dhc_map.svh"
module dhc_regs
  import dhc_pkg::*;
#(
  parameter int unsigned RING_HOLD_CYC = `DHC_RING_HOLD_MS * (`DHC_CLK_HZ / 1000)
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  input  wire logic      frame_start,
  input  wire logic      prim_lsb,
  input  wire logic      secondary_sync_pin,
  input  wire logic      sec_valid,
  input  wire dhc_cmd_t  sec_cmd,
  input  wire logic      hook_pin,
  input  wire dhc_line_t line_in,
  output dhc_ctrl_t      ctrl,
  output logic           line_offhook,
  output logic           ring_active,
  output logic [7:0]     rd_data,
  output logic           rd_valid
);

  logic [7:0]     regs [`DHC_REG_FIRST:`DHC_REG_LAST];
  logic [7:0]     next_regs [`DHC_REG_FIRST:`DHC_REG_LAST];
  logic           link_err;
  logic           next_link_err;
  logic           next_ring_active;
  logic [27:0]    ring_cnt;
  logic [27:0]    next_ring_cnt;
  logic           next_line_offhook;
  dhc_sec_state_t sec_state;
  dhc_sec_state_t next_sec_state;
  logic [7:0]     next_rd_data;
  logic           next_rd_valid;
  logic [7:0]     read_mux;
  logic           sec_req;
  logic           wr_en;
  logic           rd_en;
  logic           soft_reset;
  logic           pin_active;
  logic           offhook_req;

  function automatic logic [7:0] wmask_of(input logic [4:0] idx);
    case (idx)
      `DHC_REG_MAIN:     wmask_of = `DHC_WM_MAIN;
      `DHC_REG_PATH:     wmask_of = `DHC_WM_PATH;
      `DHC_REG_LINE:     wmask_of = `DHC_WM_LINE;
      `DHC_REG_LINE_TWO: wmask_of = `DHC_WM_LINE_TWO;
      `DHC_REG_PLL1_DIV: wmask_of = `DHC_WM_FULL;
      `DHC_REG_PLL1_MUL: wmask_of = `DHC_WM_FULL;
      `DHC_REG_PLL2:     wmask_of = `DHC_WM_FULL;
      `DHC_REG_PLL_MODE: wmask_of = `DHC_WM_PLL_MODE;
      `DHC_REG_GAIN_VER: wmask_of = `DHC_WM_GAIN_VER;
      `DHC_REG_CHAIN:    wmask_of = `DHC_WM_FULL;
      `DHC_REG_GAIN:     wmask_of = `DHC_WM_FULL;
      `DHC_REG_FILTER:   wmask_of = `DHC_WM_FILTER;
      `DHC_REG_CAL:      wmask_of = `DHC_WM_CAL;
      default:           wmask_of = `DHC_WM_NONE;
    endcase
  endfunction

  function automatic logic [7:0] reset_of(input logic [4:0] idx);
    case (idx)
      `DHC_REG_PATH:     reset_of = `DHC_RST_PATH;
      `DHC_REG_LINE_TWO: reset_of = `DHC_RST_LINE_TWO;
      default:           reset_of = `DHC_RST_ZERO;
    endcase
  endfunction

  // request for a secondary frame, taken at each primary frame start
  always_comb begin
    // RL6: sync pin starts
    if (regs[`DHC_REG_MAIN][`DHC_B_FORMAT]) begin
      sec_req = secondary_sync_pin;
    end else begin
      // RL5: data LSB requests
      sec_req = prim_lsb;
    end
  end

  // unmapped and reserved addresses pass here too; their all-zero write masks keep writes from storing
  assign wr_en = sec_valid && (sec_state == DHC_SEC_WAIT) && !sec_cmd.rd;
  assign rd_en = sec_valid && (sec_state == DHC_SEC_WAIT) && sec_cmd.rd;

  // RL2: soft reset strobe
  assign soft_reset = wr_en && (sec_cmd.addr == `DHC_REG_MAIN)
                      && sec_cmd.data[`DHC_B_SOFT_RESET];

  // one flop bank per address from 0x01 to 0x11, unmapped 0x03 and 0x04 included; bits outside the write mask never hold a one
  genvar gi;
  generate
    for (gi = `DHC_REG_FIRST; gi <= `DHC_REG_LAST; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (soft_reset) begin
          // RL2: back to reset values
          next_regs[gi] = reset_of(5'(gi));
        end else if (wr_en && (sec_cmd.addr == 5'(gi))) begin
          // RL3: only writable bits store
          next_regs[gi] = (regs[gi] & ~wmask_of(5'(gi)))
                          | (sec_cmd.data & wmask_of(5'(gi)));
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs[gi] <= reset_of(5'(gi));
        end else if (ce) begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // link error flag: a new error in the clearing cycle keeps the flag set
  always_comb begin
    next_link_err = link_err;
    if (soft_reset) begin
      next_link_err = 1'b0;
    end else if (wr_en && (sec_cmd.addr == `DHC_REG_STATE)
                 && !sec_cmd.data[`DHC_B_LINK_ERR]) begin
      next_link_err = 1'b0;
    end
    if (line_in.link_error_evt) begin
      next_link_err = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_err <= 1'b0;
    end else if (ce) begin
      link_err <= next_link_err;
    end
  end

  // hook pin level after polarity, before the enable gates it
  always_comb begin
    // RL10: pin polarity
    if (regs[`DHC_REG_LINE][`DHC_B_HOOK_POL]) begin
      pin_active = hook_pin;
    end else begin
      pin_active = !hook_pin;
    end
  end

  // RL13: pin gated by enable
  // RL14: command OR pin
  assign offhook_req = regs[`DHC_REG_LINE][`DHC_B_GO_OFFHOOK]
                       || (regs[`DHC_REG_LINE][`DHC_B_HOOK_PIN_EN] && pin_active);

  always_comb begin
    next_line_offhook = offhook_req;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_offhook <= 1'b0;
    end else if (ce) begin
      line_offhook <= next_line_offhook;
    end
  end

  // ring indicator: the hold restarts on every positive ring while on-hook, so the flag
  // drops the minimum hold after the last one, inside the allowed window
  always_comb begin
    next_ring_active = ring_active;
    next_ring_cnt    = ring_cnt;
    // RL12: off-hook clears ring
    if (soft_reset || offhook_req) begin
      next_ring_active = 1'b0;
      next_ring_cnt    = '0;
    end else if (line_in.ring_pulse) begin
      // RL12: ring restarts hold
      next_ring_active = 1'b1;
      next_ring_cnt    = 28'(RING_HOLD_CYC);
    end else if (ring_cnt != '0) begin
      next_ring_cnt = ring_cnt - 28'h0000001;
      if (ring_cnt == 28'h0000001) begin
        // RL12: timeout clears ring
        next_ring_active = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ring_active <= 1'b0;
      ring_cnt    <= '0;
    end else if (ce) begin
      ring_active <= next_ring_active;
      ring_cnt    <= next_ring_cnt;
    end
  end

  // read view: stored bits plus live status, reserved bits stay zero
  always_comb begin
    read_mux = 8'h00;
    case (sec_cmd.addr)
      `DHC_REG_MAIN: begin
        read_mux = regs[`DHC_REG_MAIN];
      end
      `DHC_REG_PATH: begin
        read_mux = regs[`DHC_REG_PATH];
      end
      `DHC_REG_LINE: begin
        read_mux              = regs[`DHC_REG_LINE];
        // RL17: live ring flag
        read_mux[`DHC_B_RING] = ring_active;
      end
      `DHC_REG_LINE_TWO: begin
        read_mux = regs[`DHC_REG_LINE_TWO];
      end
      `DHC_REG_PLL1_DIV: begin
        read_mux = regs[`DHC_REG_PLL1_DIV];
      end
      `DHC_REG_PLL1_MUL: begin
        read_mux = regs[`DHC_REG_PLL1_MUL];
      end
      `DHC_REG_PLL2: begin
        read_mux = regs[`DHC_REG_PLL2];
      end
      `DHC_REG_PLL_MODE: begin
        read_mux = regs[`DHC_REG_PLL_MODE];
      end
      `DHC_REG_VERSION: begin
        read_mux[3:0] = `DHC_HOST_VERSION;
      end
      `DHC_REG_STATE: begin
        // RL17: live line status
        read_mux[`DHC_B_LINK_ERR]  = link_err;
        read_mux[`DHC_B_FRAME_DET] = line_in.link_frame_detect;
        read_mux[3:0]              = line_in.loop_current;
      end
      `DHC_REG_GAIN_VER: begin
        read_mux                 = regs[`DHC_REG_GAIN_VER];
        read_mux[`DHC_B_LINE_ID] = line_in.line_id_bit;
        read_mux[5:2]            = line_in.line_version;
      end
      `DHC_REG_CHAIN: begin
        read_mux = regs[`DHC_REG_CHAIN];
      end
      `DHC_REG_GAIN: begin
        read_mux = regs[`DHC_REG_GAIN];
      end
      `DHC_REG_FILTER: begin
        read_mux = regs[`DHC_REG_FILTER] | `DHC_FILTER_FIXED;
      end
      `DHC_REG_CAL: begin
        read_mux = regs[`DHC_REG_CAL];
      end
      default: begin
        // RL3: reserved and unmapped read zero
        read_mux = 8'h00;
      end
    endcase
  end

  // secondary frame sequencing; a read answer leaves in the next frame
  always_comb begin
    next_sec_state = sec_state;
    next_rd_data   = rd_data;
    next_rd_valid  = 1'b0;
    case (sec_state)
      DHC_SEC_IDLE: begin
        if (frame_start && sec_req) begin
          next_sec_state = DHC_SEC_WAIT;
        end
      end
      DHC_SEC_WAIT: begin
        if (rd_en) begin
          // RL17: capture read value
          next_rd_data   = read_mux;
          next_sec_state = DHC_SEC_ANSWER;
        end else if (wr_en) begin
          next_sec_state = DHC_SEC_IDLE;
        end else if (frame_start && !sec_req) begin
          next_sec_state = DHC_SEC_IDLE;
        end
      end
      // a read blocks new windows until its answer frame has gone out
      DHC_SEC_ANSWER: begin
        if (frame_start) begin
          // RL17: answer next frame
          next_rd_valid  = 1'b1;
          next_sec_state = sec_req ? DHC_SEC_WAIT : DHC_SEC_IDLE;
        end
      end
      default: begin
        next_sec_state = DHC_SEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_state <= DHC_SEC_IDLE;
      rd_data   <= 8'h00;
      rd_valid  <= 1'b0;
    end else if (ce) begin
      sec_state <= next_sec_state;
      rd_data   <= next_rd_data;
      rd_valid  <= next_rd_valid;
    end
  end

  // control outputs are plain wires from the register flops
  always_comb begin
    // RL4: barrier loopback
    ctrl.barrier_loopback_en = regs[`DHC_REG_MAIN][`DHC_B_BARRIER_LOOP];
    ctrl.frame_format_sel    = regs[`DHC_REG_MAIN][`DHC_B_FORMAT];
    // RL7: analog loopback
    ctrl.analog_loop_en      = regs[`DHC_REG_PATH][`DHC_B_ANALOG_LOOP];
    // RL8: hybrid connect
    ctrl.hybrid_connect      = regs[`DHC_REG_PATH][`DHC_B_HYBRID];
    // RL9: receive enable
    ctrl.receive_path_en     = regs[`DHC_REG_PATH][`DHC_B_RX_EN];
    ctrl.hook_pin_polarity   = regs[`DHC_REG_LINE][`DHC_B_HOOK_POL];
    // RL11: on-hook monitoring
    ctrl.onhook_monitor_en   = regs[`DHC_REG_LINE][`DHC_B_MONITOR];
    ctrl.hook_pin_en         = regs[`DHC_REG_LINE][`DHC_B_HOOK_PIN_EN];
    ctrl.go_offhook          = regs[`DHC_REG_LINE][`DHC_B_GO_OFFHOOK];
    ctrl.charge_pump_en      = regs[`DHC_REG_LINE_TWO][`DHC_B_PUMP_EN];
    // RL15: line side powerdown
    ctrl.line_side_powerdown = regs[`DHC_REG_LINE_TWO][`DHC_B_LINE_PD];
    ctrl.host_powerdown      = regs[`DHC_REG_LINE_TWO][`DHC_B_HOST_PD];
    ctrl.aout_tx_lvl         = {regs[`DHC_REG_LINE_TWO][6], regs[`DHC_REG_LINE_TWO][1]};
    ctrl.aout_rx_lvl         = {regs[`DHC_REG_LINE_TWO][5], regs[`DHC_REG_LINE_TWO][0]};
    ctrl.pll1_div            = regs[`DHC_REG_PLL1_DIV];
    ctrl.pll1_mul            = regs[`DHC_REG_PLL1_MUL];
    ctrl.pll2_ratio          = regs[`DHC_REG_PLL2];
    ctrl.pll_mode            = regs[`DHC_REG_PLL_MODE][0];
    ctrl.chain_cfg           = regs[`DHC_REG_CHAIN];
    ctrl.gain_cfg            = regs[`DHC_REG_GAIN];
    ctrl.filter_en           = regs[`DHC_REG_FILTER][`DHC_B_FILTER_EN];
    ctrl.cal_manual          = regs[`DHC_REG_CAL][`DHC_B_CAL_MANUAL];
    ctrl.cal_auto_off        = regs[`DHC_REG_CAL][`DHC_B_CAL_AUTO_OFF];
    ctrl.gain_trim           = regs[`DHC_REG_GAIN_VER][1:0];
  end

endmodule

/* File: testbench/dhc_regs_asserts.sv */
// port checker of the control bank
`timescale 1ns/10ps
module dhc_regs_asserts
  import dhc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       frame_start,
  input wire logic       sec_valid,
  input wire dhc_cmd_t   sec_cmd,
  input wire logic       hook_pin,
  input wire dhc_line_t  line_in,
  input wire dhc_ctrl_t  ctrl,
  input wire logic       line_offhook,
  input wire logic       ring_active,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_OFFHOOK: assert property ($past(ce) |-> line_offhook ==
    $past(ctrl.go_offhook | (ctrl.hook_pin_en & (ctrl.hook_pin_polarity ? hook_pin : !hook_pin))))
    else $error("off-hook output wrong");
  AST_RING_SET: assert property (ce && line_in.ring_pulse && !ctrl.go_offhook
    && !ctrl.hook_pin_en |=> ring_active) else $error("ring not flagged");
  AST_RING_OH: assert property (ce && ctrl.go_offhook && $past(ctrl.go_offhook)
    |=> !ring_active) else $error("ring kept while off-hook");
  AST_RING_CAUSE: assert property ($rose(ring_active) |-> $past(line_in.ring_pulse))
    else $error("ring flag without pulse");
  AST_RD_ONE: assert property (rd_valid |=> !rd_valid)
    else $error("read strobe too long");
  AST_RD_FRAME: assert property (rd_valid |-> $past(frame_start))
    else $error("read answer off frame");
  AST_RD_HOLD: assert property (!$stable(rd_data) |-> $past(sec_valid) || $past(sec_valid, 2))
    else $error("read data moved alone");
  AST_CTRL_CAUSE: assert property (!$stable(ctrl) |-> $past(sec_valid) || $past(sec_valid, 2))
    else $error("control moved without write");
  AST_RESET_VALS: assert property ($past(rst) |-> ctrl.hybrid_connect &&
    ctrl.receive_path_en && ctrl.line_side_powerdown && !ring_active && !line_offhook)
    else $error("bad reset values");

  cover property (rd_valid);
  cover property (ring_active ##1 !ring_active);
  cover property (line_offhook && !ctrl.go_offhook);
endmodule

bind dhc_regs dhc_regs_asserts i_chk (.clk, .rst, .ce, .frame_start, .sec_valid, .sec_cmd,
  .hook_pin, .line_in, .ctrl, .line_offhook, .ring_active, .rd_data, .rd_valid);

/* File: testbench/dhc_far_model.sv */
// far side: serial frame timing and line-side chip status
`timescale 1ns/10ps
module dhc_far_model
  import dhc_pkg::*;
#(
  parameter int         FRAME    = 16,
  parameter logic [3:0] LOOP_LVL = 4'h5,
  parameter logic [3:0] LINE_VER = 4'h5
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic powerdown,
  input  wire logic ring_req,
  input  wire logic err_req,
  output logic      frame_start,
  output dhc_line_t line_in
);
  int cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      frame_start <= 1'b0;
      line_in <= '0;
    end else begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      frame_start <= (cnt == FRAME - 1);
      line_in.link_frame_detect <= !powerdown;
      // status is junk until the link is up, so it toggles
      line_in.loop_current <= powerdown ? ~line_in.loop_current : LOOP_LVL;
      line_in.line_id_bit <= !powerdown;
      line_in.line_version <= powerdown ? 4'h0 : LINE_VER;
      line_in.ring_pulse <= ring_req;
      line_in.link_error_evt <= err_req;
    end
  end
endmodule

/* File: testbench/dhc_regs_tb.sv */
// self-checking bench of the control bank
`timescale 1ns/10ps
module dhc_regs_tb
  import dhc_pkg::*;
();
  localparam int RH = 200;
  logic       clk = 1'b0, rst = 1'b1, prim_lsb = 1'b0, sync = 1'b0;
  logic       sec_valid = 1'b0, hook_pin = 1'b0, ring_req = 1'b0, err_req = 1'b0;
  logic       req_lsb = 1'b1, req_sync = 1'b1, ok;
  logic       frame_start, line_offhook, ring_active, rd_valid;
  logic [7:0] q, rd_data;
  dhc_cmd_t   sec_cmd = '0;
  dhc_line_t  line_in;
  dhc_ctrl_t  ctrl;
  int         err_total = 0, total_checks = 0;
  logic [7:0] rv [19] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
  logic [7:0] wm [19] = '{8'h00, 8'h03, 8'h0B, 8'h00, 8'h00, 8'h1B, 8'hFB, 8'hFF, 8'hFF,
    8'hFF, 8'h01, 8'h00, 8'h00, 8'h03, 8'hFF, 8'hFF, 8'h10, 8'h60, 8'h00};

  always #12.5 clk = ~clk;

  dhc_regs #(.RING_HOLD_CYC(RH)) i_dut (.clk, .rst, .ce(1'b1), .frame_start, .prim_lsb,
    .secondary_sync_pin(sync), .sec_valid, .sec_cmd, .hook_pin, .line_in, .ctrl,
    .line_offhook, .ring_active, .rd_data, .rd_valid);
  dhc_far_model i_far (.clk, .rst, .powerdown(ctrl.line_side_powerdown), .ring_req,
    .err_req, .frame_start, .line_in);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_fs;
    do @(posedge clk); while (frame_start !== 1'b1);
  endtask

  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d);
    int n;
    wait_fs();
    prim_lsb <= req_lsb;
    sync <= req_sync;
    wait_fs();
    prim_lsb <= 1'b0;
    sync <= 1'b0;
    sec_valid <= 1'b1;
    sec_cmd <= {rd, a, d};
    @(posedge clk);
    sec_valid <= 1'b0;
    ok = 1'b0;
    n = 0;
    while (rd && !ok && n < 64) begin
      @(posedge clk);
      ok = (rd_valid === 1'b1);
      n++;
    end
    q = rd_data;
  endtask

  task automatic wr(input int a, input logic [7:0] d);
    xfer(1'b0, 5'(a), d);
    // the write lands at the edge that takes it; let that edge settle
    @(posedge clk);
  endtask

  task automatic rdchk(input int a, input logic [7:0] e);
    xfer(1'b1, 5'(a), 8'h00);
    if (a == 12 && ctrl.line_side_powerdown)
      q[3:0] = 4'h0;
    chk(ok ? q : 8'hXX, e);
  endtask

  task automatic chk_reset;
    for (int a = 0; a < 19; a++)
      rdchk(a == 18 ? 31 : a, rv[a]);
  endtask

  task automatic ring;
    ring_req <= 1'b1;
    @(posedge clk);
    ring_req <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    wt(20);
    rst <= 1'b0;
    chk_reset();
    for (int a = 1; a < 18; a++) begin
      if (a != 3 && a != 4)
        wr(a, 8'h77);
      rdchk(a, (8'h77 & wm[a]) | (rv[a] & ~wm[a]));
    end
    chk(ctrl.barrier_loopback_en, 1'b1);
    wr(1, 8'h80);
    chk_reset();
    for (int m = 0; m < 2; m++) begin
      wr(1, 8'(m));
      req_lsb = m[0];
      req_sync = !m[0];
      wr(2, 8'h00);
      xfer(1'b1, 5'h02, 8'h00);
      chk(ok, 1'b0);
      req_lsb = !m[0];
      req_sync = m[0];
      rdchk(2, 8'h03);
      req_lsb = 1'b1;
      req_sync = 1'b1;
    end
    // one test mode at a time: barrier loopback is off here
    wr(2, 8'h0B);
    chk(ctrl.analog_loop_en, 1'b1);
    wr(2, 8'h01);
    chk(ctrl.hybrid_connect, 1'b0);
    chk(ctrl.receive_path_en, 1'b1);
    wr(2, 8'h02);
    chk(ctrl.receive_path_en, 1'b0);
    wr(5, 8'h08);
    chk(ctrl.onhook_monitor_en, 1'b1);
    for (int i = 0; i < 16; i++) begin
      hook_pin <= i[1];
      wr(5, {3'h0, i[3], 2'h0, i[2], i[0]});
      wt(2);
      chk(line_offhook, i[0] | (i[2] & (i[3] ? i[1] : !i[1])));
    end
    wr(5, 8'h00);
    ring();
    wt(3);
    chk(ring_active, 1'b1);
    rdchk(5, 8'h04);
    wr(5, 8'h01);
    wt(3);
    chk(ring_active, 1'b0);
    wr(5, 8'h00);
    ring();
    wt(RH - 2);
    chk(ring_active, 1'b1);
    wt(6);
    chk(ring_active, 1'b0);
    // clock generator set before the line side wakes
    wr(7, 8'h01);
    wr(8, 8'h03);
    wr(6, 8'h60);
    rdchk(12, 8'h45);
    rdchk(13, 8'h54);
    err_req <= 1'b1;
    wt(1);
    err_req <= 1'b0;
    rdchk(12, 8'hC5);
    wr(12, 8'h00);
    rdchk(12, 8'h45);
    wrap_up();
  end

  initial begin
    wt(30000);
    err_total++;
    wrap_up();
  end
endmodule
